// ---- hdl/config_eeprom_programmer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_prog_defines.svh"

module config_eeprom_programmer
  import eeprom_prog_pkg::*;
#(
  parameter int HALF_DIV = `EE_HALF_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [1:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // control clock out and back in
  output logic o_eeprom_clock_out,
  input wire logic i_eeprom_clock_in,
  // eeprom pins
  output logic o_eeprom_enable_out,
  output logic o_eeprom_scl_out,
  output logic o_eeprom_scl_oe,
  input wire logic i_eeprom_sda_in,
  output logic o_eeprom_sda_out,
  output logic o_eeprom_sda_oe
);

  // ==========================================
  // clock divider

  // control clock made here, leaves and returns via top level
  eeprom_clk_div #(
    .HALF_DIV(HALF_DIV)
  ) u_div (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .o_clk_div(o_eeprom_clock_out)
  );

  // ==========================================
  // input synchronisers

  logic ctrl_clk_s;
  logic sda_s;
  logic req_tgl_s;
  logic done_tgl_s;
  logic req_tgl_reg;
  logic done_tgl_reg;

  // returned clock, data pin and both handshake toggles
  eeprom_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async({i_eeprom_clock_in, i_eeprom_sda_in, req_tgl_reg, done_tgl_reg}),
    .o_sync({ctrl_clk_s, sda_s, req_tgl_s, done_tgl_s})
  );

  // ==========================================
  // bus side registers

  logic enable_reg;
  logic busy_reg;
  logic nack_reg;
  logic done_seen_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  ee_op_t op_reg;

  // command decode, start has priority
  function automatic ee_op_t decode_cmd(input logic [4:0] bits);
    ee_op_t op;
    op = OP_WAIT;
    if (bits[`EE_CMD_START]) op = OP_START;
    else if (bits[`EE_CMD_STOP]) op = OP_STOP;
    else if (bits[`EE_CMD_WRITE]) op = OP_WRITE;
    else if (bits[`EE_CMD_READ_ACK]) op = OP_READ_ACK;
    else if (bits[`EE_CMD_READ_NACK]) op = OP_READ_NACK;
    return op;
  endfunction

  // access decode
  wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr = bus_req & i_wb_we;
  wire [1:0] idx = i_wb_adr[3:2];
  wire wr_lo = bus_wr & i_wb_sel[0];
  wire wr_hi = bus_wr & i_wb_sel[1];
  wire cmd_wr = wr_lo & (idx == `EE_IDX_CMD);
  wire wdata_wr = wr_lo & (idx == `EE_IDX_WDATA);
  wire [15:0] wr_half = i_wb_dat[15:0];
  wire ee_op_t new_op = decode_cmd(wr_half[4:0]);
  wire launch = cmd_wr & ~busy_reg & (new_op != OP_WAIT);
  wire done_evt = (done_tgl_s != done_seen_reg);

  // read mux, unused lanes and bits read zero
  logic [31:0] rd_mux;
  logic [7:0] ee_shift_reg;
  logic ee_nack_reg;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      `EE_IDX_CMD: begin
        rd_mux[`EE_CMD_ENABLE] = enable_reg;
        rd_mux[`EE_CMD_BUSY] = busy_reg;
      end
      `EE_IDX_WDATA: rd_mux[7:0] = wdata_reg;
      `EE_IDX_RDATA: rd_mux[7:0] = rdata_reg;
      `EE_IDX_STATUS: begin
        rd_mux[`EE_STAT_BUSY] = busy_reg;
        rd_mux[`EE_STAT_NACK] = nack_reg;
      end
    endcase
  end

  // single-cycle ack, every access answered
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= (bus_req & ~i_wb_we) ? rd_mux : 32'h0000_0000;
    end
  end

  // control registers; high half lane has no storage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      enable_reg <= `EE_RST_ENABLE;
      wdata_reg <= `EE_RST_BYTE;
      op_reg <= OP_WAIT;
    end else begin
      if (cmd_wr) enable_reg <= wr_half[`EE_CMD_ENABLE];
      if (wdata_wr & ~busy_reg) wdata_reg <= wr_half[7:0];
      if (launch) op_reg <= new_op;
    end
  end

  // request toggle out, completion back in
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      req_tgl_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_seen_reg <= 1'b0;
      rdata_reg <= `EE_RST_BYTE;
      nack_reg <= 1'b0;
    end else begin
      if (launch) begin
        req_tgl_reg <= ~req_tgl_reg;
        busy_reg <= 1'b1;
      end else if (done_evt) begin
        busy_reg <= 1'b0;
      end
      if (done_evt) begin
        done_seen_reg <= done_tgl_s;
        rdata_reg <= ee_shift_reg;
        nack_reg <= ee_nack_reg;
      end
    end
  end

  // ==========================================
  // slow eeprom machine

  logic ctrl_clk_d_reg;
  logic req_seen_reg;
  logic [1:0] step_reg;
  logic [2:0] bit_reg;
  logic scl_reg;
  logic sda_reg;
  logic sda_drive_reg;
  logic ack_drive_reg;
  logic ack_val_reg;
  ee_state_t state_reg;

  // one step per rising edge of returned clock
  wire tick = ctrl_clk_s & ~ctrl_clk_d_reg;
  wire req_evt = (req_tgl_s != req_seen_reg);
  wire last_step = (step_reg == `EE_LAST_STEP);
  wire last_bit = (bit_reg == 3'h0);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_clk_d_reg <= 1'b0;
    end else begin
      ctrl_clk_d_reg <= ctrl_clk_s;
    end
  end

  // instruction sequencer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ST_WAIT;
      step_reg <= 2'h0;
      bit_reg <= `EE_LAST_BIT;
      req_seen_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sda_drive_reg <= 1'b1;
      ack_drive_reg <= 1'b0;
      ack_val_reg <= 1'b0;
      ee_shift_reg <= `EE_RST_BYTE;
      ee_nack_reg <= 1'b0;
    end else if (tick) begin
      step_reg <= step_reg + 2'h1;
      unique case (state_reg)
        ST_WAIT: begin
          step_reg <= 2'h0;
          bit_reg <= `EE_LAST_BIT;
          if (req_evt) begin
            req_seen_reg <= req_tgl_s;
            ee_shift_reg <= wdata_reg;
            ack_val_reg <= (op_reg == OP_READ_NACK);
            unique case (op_reg)
              OP_START: state_reg <= ST_START;
              OP_STOP: state_reg <= ST_STOP;
              OP_WRITE: state_reg <= ST_SEND;
              OP_READ_ACK, OP_READ_NACK: state_reg <= ST_RECV;
              default: state_reg <= ST_WAIT;
            endcase
          end
        end
        ST_START: begin
          unique case (step_reg)
            2'h0: begin
              sda_drive_reg <= 1'b1;
              sda_reg <= 1'b1;
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: sda_reg <= 1'b0;
            2'h3: scl_reg <= 1'b0;
          endcase
        end
        ST_STOP: begin
          unique case (step_reg)
            2'h0: begin
              sda_drive_reg <= 1'b1;
              sda_reg <= 1'b0;
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: sda_reg <= 1'b1;
            2'h3: scl_reg <= 1'b1;
          endcase
        end
        ST_SEND, ST_RECV: begin
          unique case (step_reg)
            2'h0: begin
              sda_drive_reg <= (state_reg == ST_SEND);
              sda_reg <= ee_shift_reg[7];
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: if (state_reg == ST_RECV) ee_shift_reg <= {ee_shift_reg[6:0], sda_s};
            2'h3: begin
              scl_reg <= 1'b0;
              if (state_reg == ST_SEND) ee_shift_reg <= {ee_shift_reg[6:0], 1'b0};
              bit_reg <= bit_reg - 3'h1;
              if (last_bit) begin
                ack_drive_reg <= (state_reg == ST_RECV);
                state_reg <= ST_ACK;
              end
            end
          endcase
        end
        ST_ACK: begin
          unique case (step_reg)
            2'h0: begin
              sda_drive_reg <= ack_drive_reg;
              sda_reg <= ack_val_reg;
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: if (!ack_drive_reg) ee_nack_reg <= sda_s;
            2'h3: scl_reg <= 1'b0;
          endcase
        end
        default: state_reg <= ST_WAIT;
      endcase
      // finished instruction reports back
      if (state_reg != ST_WAIT && last_step &&
          !(state_reg inside {ST_SEND, ST_RECV} && !last_bit)) begin
        if (state_reg != ST_ACK && (state_reg == ST_SEND || state_reg == ST_RECV)) begin
          state_reg <= ST_ACK;
        end else begin
          state_reg <= ST_WAIT;
          done_tgl_reg <= ~done_tgl_reg;
        end
      end
    end
  end

  // ==========================================
  // pin drivers

  // drivers enabled only while serial enable is set
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_eeprom_enable_out <= 1'b0;
      o_eeprom_scl_out <= 1'b1;
      o_eeprom_scl_oe <= 1'b0;
      o_eeprom_sda_out <= 1'b1;
      o_eeprom_sda_oe <= 1'b0;
    end else begin
      o_eeprom_enable_out <= enable_reg;
      o_eeprom_scl_out <= scl_reg;
      o_eeprom_scl_oe <= enable_reg;
      o_eeprom_sda_out <= sda_reg;
      o_eeprom_sda_oe <= enable_reg & sda_drive_reg;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/eeprom_prog_defines.svh ----
// Summary of operation
// - Divider makes eeprom control clock, 393 KHz nominal
// - Bus clock at least four times control clock
// - Control clock leaves block, re-enters separately
// - Enable output follows serial enable bit D07
// - Enable turns on clock and data drivers
// - Wishbone slave, 32-bit port, 16-bit granularity
// - Every cycle ends with ACK_O only
// - Bus transactions synchronous to bus clock
// - Software registers live in bus clock domain
// - Handshake carries requests and results across domains
// - Slow state machine drives all eeprom signalling
// - Six instructions: five command bits plus wait
// - Four primitive steps per requested instruction
// - Bit counter loops steps across a byte
// - Either endianness accepted, single accesses only
// - Synchronous resets only, no asynchronous ones
`ifndef EEPROM_PROG_DEFINES_SVH
`define EEPROM_PROG_DEFINES_SVH

// ==========================================
// clocking
`define EE_BUS_CLK_HZ 125000000
`define EE_CTRL_CLK_HZ 393000
`define EE_HALF_DIV (`EE_BUS_CLK_HZ / (2 * `EE_CTRL_CLK_HZ))

// ==========================================
// register indices (word address bits [3:2])
`define EE_IDX_CMD 2'h0
`define EE_IDX_WDATA 2'h1
`define EE_IDX_RDATA 2'h2
`define EE_IDX_STATUS 2'h3

// ==========================================
// command register fields
`define EE_CMD_START 0
`define EE_CMD_STOP 1
`define EE_CMD_WRITE 2
`define EE_CMD_READ_ACK 3
`define EE_CMD_READ_NACK 4
`define EE_CMD_ENABLE 7
`define EE_CMD_BUSY 8

// ==========================================
// status register fields
`define EE_STAT_BUSY 0
`define EE_STAT_NACK 1

// ==========================================
// reset values and counter limits
`define EE_RST_ENABLE 1'b0
`define EE_RST_BYTE 8'h00
`define EE_LAST_STEP 2'h3
`define EE_LAST_BIT 3'h7

`endif

// ---- hdl/eeprom_prog_pkg.sv ----
`default_nettype none
package eeprom_prog_pkg;

  // instruction set of the slow machine
  typedef enum logic [2:0] {
    OP_WAIT = 3'h0,
    OP_START = 3'h1,
    OP_STOP = 3'h2,
    OP_WRITE = 3'h3,
    OP_READ_ACK = 3'h4,
    OP_READ_NACK = 3'h5
  } ee_op_t;

  // slow machine states
  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_START = 3'h1,
    ST_STOP = 3'h2,
    ST_SEND = 3'h3,
    ST_RECV = 3'h4,
    ST_ACK = 3'h5
  } ee_state_t;

endpackage

`default_nettype wire

// ---- hdl/eeprom_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module eeprom_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // signals
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_reg;

  // two flops, only the second is read outside
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage1_reg <= '0;
      o_sync <= '0;
    end else begin
      stage1_reg <= i_async;
      o_sync <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/eeprom_clk_div.sv ----
`timescale 1ns/1ns
`default_nettype none

module eeprom_clk_div #(
  parameter int HALF_DIV = 159
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // divided clock
  output logic o_clk_div
);

  logic [15:0] count_reg;
  wire wrap = (count_reg == 16'(HALF_DIV - 1));

  // toggle every half period
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      count_reg <= 16'h0000;
      o_clk_div <= 1'b0;
    end else if (wrap) begin
      count_reg <= 16'h0000;
      o_clk_div <= ~o_clk_div;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/eeprom_prog_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module eeprom_prog_monitor #(
  parameter int HALF_DIV = 159
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // eeprom side
  input wire logic o_eeprom_clock_out,
  input wire logic o_eeprom_enable_out,
  input wire logic o_eeprom_scl_oe,
  input wire logic o_eeprom_sda_oe
);
  // ========
  // helpers
  wire logic req = i_wb_cyc && i_wb_stb;
  wire logic cmd_wr = o_wb_ack && i_wb_we && i_wb_adr[3:2] == 2'h0;
  int run_reg;
  logic seen_reg;
  // cycles since the divided clock last moved
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_reg <= 0;
      seen_reg <= 1'b0;
    end else if ($changed(o_eeprom_clock_out)) begin
      run_reg <= 0;
      seen_reg <= 1'b1;
    end else begin
      run_reg <= run_reg + 1;
    end
  end
  // ========
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence take_s;
    req && !o_wb_ack;
  endsequence
  ack_resp_a: assert property (take_s |=> o_wb_ack) else $error("no ack");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
  ack_cause_a: assert property (o_wb_ack |-> $past(req)) else $error("stray ack");
  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("dat");
  scl_drive_a: assert property (o_eeprom_scl_oe == o_eeprom_enable_out) else $error("scl oe");
  sda_drive_a: assert property (o_eeprom_sda_oe |-> o_eeprom_enable_out) else $error("sda oe");
  ena_cause_a: assert property ($changed(o_eeprom_enable_out) |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("enable moved");
  clk_div_a: assert property (seen_reg && $changed(o_eeprom_clock_out) |->
    run_reg == HALF_DIV - 1) else $error("divider");
endmodule
bind config_eeprom_programmer eeprom_prog_monitor #(.HALF_DIV(HALF_DIV)) eeprom_prog_monitor_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_eeprom_clock_out(o_eeprom_clock_out), .o_eeprom_enable_out(o_eeprom_enable_out),
  .o_eeprom_scl_oe(o_eeprom_scl_oe), .o_eeprom_sda_oe(o_eeprom_sda_oe));
`default_nettype wire

// ---- testbench/eeprom_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module eeprom_model (
  // sampling clock
  input wire logic i_clk,
  // wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // behaviour
  input wire logic i_rd_mode,
  input wire logic i_ack_en,
  input wire logic [7:0] i_tx_byte,
  // outputs
  output logic o_sda_low,
  output logic [7:0] o_rx_byte
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [3:0] bit_reg = 4'hf;
  // bit counter, restarted by a start condition
  always_ff @(posedge i_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (scl_q && i_scl && sda_q && !i_sda) begin
      bit_reg <= 4'hf;
    end else if (scl_q && !i_scl) begin
      bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
    end
    if (!scl_q && i_scl && bit_reg < 4'h8) begin
      o_rx_byte <= {o_rx_byte[6:0], i_sda};
    end
  end
  // only pulls low, only in its own bit slots
  assign o_sda_low = i_rd_mode ? (bit_reg < 4'h8 && !i_tx_byte[3'h7 - bit_reg[2:0]]) :
    (bit_reg == 4'h8 && i_ack_en);
endmodule
`default_nettype wire

// ---- testbench/config_eeprom_programmer_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module config_eeprom_programmer_test;
  // ========
  // stimulus and wires
  localparam int HD = 2;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [1:0] sel = 2'h0;
  logic [31:0] wdat = 32'h0;
  logic rd_mode = 1'b0;
  logic ack_en = 1'b1;
  logic [7:0] tx = 8'h0;
  logic [31:0] rdat, q;
  logic ack, eeprom_control_clock, ena, scl_o, scl_oe, sda_o, sda_oe, sda_low;
  logic [7:0] rx;
  int n_fail = 0;
  int cmp_count = 0;
  // released lines float high
  wire logic scl = scl_oe ? scl_o : 1'b1;
  wire logic sda = !(sda_oe && !sda_o) && !sda_low;
  always #4 clk = ~clk;
  config_eeprom_programmer #(.HALF_DIV(HD)) config_eeprom_programmer_inst (
    .i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_eeprom_clock_out(eeprom_control_clock), .i_eeprom_clock_in(eeprom_control_clock), .o_eeprom_enable_out(ena),
    .o_eeprom_scl_out(scl_o), .o_eeprom_scl_oe(scl_oe), .i_eeprom_sda_in(sda),
    .o_eeprom_sda_out(sda_o), .o_eeprom_sda_oe(sda_oe));
  eeprom_model eeprom_model_inst (.i_clk(clk), .i_scl(scl), .i_sda(sda),
    .i_rd_mode(rd_mode), .i_ack_en(ack_en), .i_tx_byte(tx), .o_sda_low(sda_low),
    .o_rx_byte(rx));
  // ========
  // shared tasks
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] s);
    int k;
    logic got;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    got = (ack === 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (!got) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 2'h1);
    check(q, exp);
  endtask
  // poll status until the instruction is done
  task automatic idle;
    int k;
    for (k = 0; k < 300; k++) begin
      bus(1'b0, 4'hc, 32'h0, 2'h1);
      if (q[0] === 1'b0) break;
    end
    if (k == 300) begin
      n_fail++;
      conclude();
    end
  endtask
  // ========
  // scenarios
  task automatic t_enable;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'hc, 32'h0);
    check({ena, scl_oe, sda_oe}, 3'h0);
    bus(1'b1, 4'h0, 32'h80, 2'h1);
    @(posedge clk);
    check({ena, scl_oe}, 2'h3);
    bus(1'b1, 4'h0, 32'h0, 2'h0);
    rd_chk(4'h0, 32'h80);
    bus(1'b1, 4'h4, 32'hffff12a5, 2'h1);
    rd_chk(4'h4, 32'ha5);
  endtask
  task automatic t_start;
    bus(1'b1, 4'h0, 32'h83, 2'h1);
    rd_chk(4'hc, 32'h1);
    idle();
    check({scl, sda}, 2'h0);
  endtask
  task automatic t_write;
    bus(1'b1, 4'h0, 32'h84, 2'h1);
    bus(1'b1, 4'h4, 32'h5a, 2'h1);
    idle();
    check(rx, 8'ha5);
    rd_chk(4'hc, 32'h0);
    rd_chk(4'h4, 32'ha5);
    ack_en <= 1'b0;
    bus(1'b1, 4'h0, 32'h84, 2'h1);
    idle();
    rd_chk(4'hc, 32'h2);
  endtask
  task automatic t_read;
    rd_mode <= 1'b1;
    tx <= 8'h3c;
    bus(1'b1, 4'h0, 32'h88, 2'h1);
    idle();
    rd_chk(4'h8, 32'h3c);
    tx <= 8'hc3;
    bus(1'b1, 4'h0, 32'h90, 2'h1);
    idle();
    rd_chk(4'h8, 32'hc3);
    rd_mode <= 1'b0;
  endtask
  task automatic t_stop;
    bus(1'b1, 4'h0, 32'h82, 2'h1);
    idle();
    check({scl, sda}, 2'h3);
    bus(1'b1, 4'h0, 32'h0, 2'h1);
    @(posedge clk);
    check({ena, scl_oe, sda_oe}, 3'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_enable();
    t_start();
    t_write();
    t_read();
    t_stop();
    conclude();
  end
endmodule
`default_nettype wire
